//--- rtl/idle_cfg_pkg.sv
package idle_cfg_pkg;
   localparam logic [11:0] CFG_INDEX     = 12'h001;
   localparam logic [11:0] CFG_ADDR      = 12'h004;
   localparam logic [11:0] STATUS_ADDR   = 12'h010;
   localparam logic [11:0] MASK_ADDR     = 12'h014;
   localparam logic [11:0] ACTIVE_ADDR   = 12'h018;
   localparam int          CPU_BIT       = 0;
   localparam int          MASTER_BIT    = 1;
   localparam int          ICACHE_BIT    = 2;
   localparam int          PERI_BIT      = 3;
   localparam int          CLK_BIT       = 4;
   localparam int          EXT_MEM_INTERFACE_BIT      = 5;
   localparam int          IO_BIT        = 6;
   localparam int          DMA_BIT       = 7;
   localparam int          FETCH_BIT     = 8;
   localparam int          CLKEXT_BIT    = 9;
   localparam logic [15:0] CFG_WR_MASK   = 16'h03FF;
   localparam logic [15:0] CFG_RESET     = 16'h0000;
   localparam logic [15:0] CLK_NEED_MASK = 16'h03F7;
   localparam int          EV_BUSERR     = 0;
   localparam int          EV_IDLE       = 1;
   localparam logic [1:0]  EV_MASK_ALL   = 2'h3;

   // gated domains, one enable bit per domain, as applied by the last IDLE
   typedef struct packed {
      logic clkgen;
      logic fetch;
      logic dma_host;
      logic io_space;
      logic ext_mem;
   } domain_t;

   typedef struct packed {
      logic [15:0] cfg;
      domain_t     idle;
      logic [1:0]  status;
      logic [1:0]  mask;
      logic        irq;
      logic        buserr;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } state_t;
endpackage

//--- rtl/idle_domain_config.sv
`timescale 1ns/1ps
`default_nettype none
module idle_domain_config
(
   // clock and reset
   input  wire logic                  core_clk_in,
   input  wire logic                  sys_rst_in,
   // apb slave
   input  wire logic                  psel_in,
   input  wire logic                  penable_in,
   input  wire logic                  pwrite_in,
   input  wire logic [11:0]           paddr_in,
   input  wire logic [31:0]           pwdata_in,
   output var  logic [31:0]           prdata_out,
   output var  logic                  pready_out,
   output var  logic                  pslverr_out,
   // idle instruction strobe from the core
   input  wire logic                  idle_exec_in,
   // domain idle controls and events
   output var  idle_cfg_pkg::domain_t idle_out,
   output var  logic                  bus_error_out,
   output var  logic                  irq_out
);
   import idle_cfg_pkg::*;

   // how the block behaves, for whoever picks it up next:
   // software parks idle requests in one configuration word, and nothing
   // happens to any domain until the core signals that IDLE executes;
   // on that strobe the stored bits are copied into the gated domain
   // outputs in a single edge, so every domain switches together
   //
   // the clock generator is special: stopping it takes the whole chip down,
   // so it is only honoured when every companion bit is also set; any
   // request pattern that sets the base clock generator bit without them becomes
   // a bus error event and the clock generator keeps running
   //
   // the event status word records bus errors and applied idles; it is
   // sticky, cleared by writing ones, and a set in the same cycle wins
   // so that no event can be lost to a late clear
   //
   // the interrupt output is a plain level, high while any unmasked status
   // bit is set; software clears the cause and the level drops on the same edge as the status bit
   //
   // register words, one per aligned byte address on the apb side:
   //    configuration  - idle requests, bits 9..0 live, 15..10 read zero
   //    status         - bit 0 bus error, bit 1 idle applied, write one to clear
   //    mask           - same layout as status, a one enables the interrupt
   //    active         - readback of the gated domain outputs, read only
   // any other address answers with an error response and changes nothing
   //
   // bus timing: the access is taken on the first edge with select and
   // enable high; ready rises from that edge and the master drops the
   // request on the next one, so every access costs one wait state; the
   // ready flop also blocks a second take of the same held request
   //
   // limitation: the processor, master, cache and peripheral bits are
   // stored, and all but the peripheral bit enter the clock rule, but they drive no gated output here;
   // the domains that need them are switched by other logic
   //
   // hazard: a configuration write in the same cycle as IDLE does not
   // reach that IDLE; the strobe always sees the word stored before it

   // one packed state word; s_d is its only next-state source
   state_t      s_q;
   state_t      s_d;

   // decoded bus access, valid in the cycle before pready rises
   logic        bus_take;                    // access phase seen, answer not yet given
   logic        bus_wr;                      // taken access is a write
   logic        hit_cfg;                     // address selects the configuration word
   logic        hit_status;                  // address selects the event status word
   logic        hit_mask;                    // address selects the event mask word
   logic        hit_active;                  // address selects the domain readback
   logic        hit_any;                     // address selects any mapped word
   logic [31:0] rd_word;                     // read data for the decoded address

   // idle request decode, all taken from the stored configuration
   logic        clk_req;                     // base clock generator request bit
   logic        clk_ext;                     // extended clock generator request bit
   logic        clk_illegal;                 // clock request without every companion bit
   logic        clk_stop;                    // legal request to stop the clock generator
   domain_t     dom_next;                    // domain set that an IDLE would apply now

   // event sources and software clears
   logic [1:0]  ev_set;                      // events raised in this cycle
   logic [1:0]  ev_clr;                      // write-one-to-clear bits from software
   logic [1:0]  status_next;                 // status after set and clear

   // clock generator may only be idled with every companion bit set
   function automatic logic clk_combo_ok(input logic [15:0] c);
      clk_combo_ok = ((c & CLK_NEED_MASK) == CLK_NEED_MASK);
   endfunction

   // true when a byte address selects the given register word
   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] target);
      addr_is = (a == target);
   endfunction

   // only the implemented bits of a written configuration word survive,
   // so the reserved upper bits can never be read back as ones
   function automatic logic [15:0] cfg_filter(input logic [31:0] w);
      cfg_filter = w[15:0] & CFG_WR_MASK;
   endfunction

   // zero-extend a two-bit event field onto the bus width
   function automatic logic [31:0] ev_word(input logic [1:0] v);
      ev_word = {30'h0, v};
   endfunction

   // map the stored request bits onto the gated domain outputs
   function automatic domain_t port_bits(input logic [15:0] c, input logic stop_clk);
      domain_t d;
      d          = '0;
      d.clkgen   = stop_clk;
      d.fetch    = c[FETCH_BIT];
      d.dma_host = c[DMA_BIT];
      d.io_space = c[IO_BIT];
      d.ext_mem  = c[EXT_MEM_INTERFACE_BIT];
      port_bits  = d;
   endfunction

   // interrupt level from a status and a mask word
   function automatic logic irq_level(input logic [1:0] st, input logic [1:0] mk);
      irq_level = |(st & mk & EV_MASK_ALL);
   endfunction

   // bus decode; the access is taken once, on the edge at which pready rises
   assign bus_take   = psel_in && penable_in && !s_q.pready;
   assign bus_wr     = bus_take && pwrite_in;
   assign hit_cfg    = addr_is(paddr_in, CFG_ADDR);
   assign hit_status = addr_is(paddr_in, STATUS_ADDR);
   assign hit_mask   = addr_is(paddr_in, MASK_ADDR);
   assign hit_active = addr_is(paddr_in, ACTIVE_ADDR);
   assign hit_any    = hit_cfg || hit_status || hit_mask || hit_active;

   // read mux; an unmapped word reads zero and is flagged elsewhere
   always_comb
   begin
      rd_word = 32'h0000_0000;
      if (hit_cfg)
      begin
         rd_word = {16'h0000, s_q.cfg};
      end
      else if (hit_status)
      begin
         rd_word = ev_word(s_q.status);
      end
      else if (hit_mask)
      begin
         rd_word = ev_word(s_q.mask);
      end
      else if (hit_active)
      begin
         rd_word = {27'h0, s_q.idle};
      end
      else
      begin
         rd_word = 32'h0000_0000;
      end
   end

   // clock generator request check; works on the stored word only, so a
   // write landing in the same cycle as IDLE cannot sneak past the rule
   assign clk_req     = s_q.cfg[CLK_BIT];
   assign clk_ext     = s_q.cfg[CLKEXT_BIT];
   assign clk_illegal = clk_req && !clk_combo_ok(s_q.cfg);
   assign clk_stop    = clk_req && clk_ext && !clk_illegal;
   assign dom_next    = port_bits(s_q.cfg, clk_stop);

   // event sources; an IDLE raises exactly one of the two events
   always_comb
   begin
      ev_set = 2'h0;
      ev_clr = 2'h0;
      if (idle_exec_in)
      begin
         ev_set[EV_BUSERR] = clk_illegal;
         ev_set[EV_IDLE]   = !clk_illegal;
      end
      if (bus_wr && hit_status)
      begin
         ev_clr = pwdata_in[1:0];
      end
   end

   // set wins over a write-one clear in the same cycle
   assign status_next = (s_q.status & ~ev_clr) | ev_set;

   // next state: bus answer, register writes, idle application
   always_comb
   begin
      s_d         = s_q;
      s_d.pready  = bus_take;
      s_d.pslverr = 1'b0;
      s_d.buserr  = 1'b0;
      // read data loads once per access and holds until the next one; pslverr lasts one cycle
      if (bus_take)
      begin
         s_d.prdata  = rd_word;
         s_d.pslverr = !hit_any;                               // unmapped answers error
      end
      // writes only touch storage; no domain moves here
      if (bus_wr && hit_cfg)
      begin
         s_d.cfg = cfg_filter(pwdata_in);
      end
      if (bus_wr && hit_mask)
      begin
         s_d.mask = pwdata_in[1:0];
      end
      // settings are latched into the domains only at an IDLE
      if (idle_exec_in)
      begin
         s_d.idle   = dom_next;
         s_d.buserr = clk_illegal;
      end
      s_d.status = status_next;
      s_d.irq    = irq_level(status_next, s_d.mask);
   end

   // single state register
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in)
      begin
         s_q        <= '0;
         s_q.cfg    <= CFG_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops
   assign prdata_out    = s_q.prdata;
   assign pready_out    = s_q.pready;
   assign pslverr_out   = s_q.pslverr;
   assign idle_out      = s_q.idle;
   assign bus_error_out = s_q.buserr;
   assign irq_out       = s_q.irq;
endmodule
`default_nettype wire

//--- testbench/idle_cfg_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module idle_cfg_monitor
(
   // clock and reset
   input wire logic                  core_clk_in,
   input wire logic                  sys_rst_in,
   // apb side
   input wire logic                  psel_in,
   input wire logic                  penable_in,
   input wire logic                  pwrite_in,
   input wire logic [11:0]           paddr_in,
   input wire logic [31:0]           pwdata_in,
   input wire logic [31:0]           prdata_out,
   input wire logic                  pready_out,
   // idle side
   input wire logic                  idle_exec_in,
   input wire logic                  bus_error_out,
   input wire idle_cfg_pkg::domain_t idle_out
);
   import idle_cfg_pkg::*;
   logic [15:0] cfg_q;
   logic        full;
   // shadow of the config, so checks know what an IDLE must see
   always_ff @(posedge core_clk_in)
   begin
      if (sys_rst_in) cfg_q <= CFG_RESET;
      else if (psel_in && penable_in && !pready_out && pwrite_in && paddr_in == CFG_ADDR)
         cfg_q <= pwdata_in[15:0] & CFG_WR_MASK;
   end
   assign full = (cfg_q & CLK_NEED_MASK) == CLK_NEED_MASK;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   clk_stop_a: assert property (idle_exec_in && full |=> idle_out.clkgen && !bus_error_out)
      else $error("clkgen not idled");
   clk_run_a: assert property (idle_exec_in && !cfg_q[CLK_BIT] |=> !idle_out.clkgen)
      else $error("clkgen idled");
   ext_miss_a: assert property (idle_exec_in && cfg_q[CLK_BIT] && !cfg_q[CLKEXT_BIT]
      |=> bus_error_out && !idle_out.clkgen) else $error("no bus error");
   any_miss_a: assert property (idle_exec_in && cfg_q[CLK_BIT] && !full |=> bus_error_out)
      else $error("missed bus error");
   port_map_a: assert property (idle_exec_in |=> idle_out[3:0] == $past(cfg_q[8:5]))
      else $error("port idle wrong");
   idle_hold_a: assert property (!idle_exec_in |=> $stable(idle_out) && !bus_error_out)
      else $error("idle changed");
   cfg_read_a: assert property (pready_out && psel_in && !pwrite_in && paddr_in == CFG_ADDR
      |-> prdata_out == {16'h0000, cfg_q}) else $error("config readback");
   reset_zero_a: assert property ($fell(sys_rst_in) |-> idle_out == 5'h00)
      else $error("idle after reset");
   cover property (idle_exec_in && full);
   cover property (bus_error_out);
   cover property (pready_out && paddr_in == CFG_ADDR);
endmodule
bind idle_domain_config idle_cfg_monitor mon (.*);
`default_nettype wire

//--- testbench/idle_domain_config_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin miscompares++; \
   $display("Error at %0t: %h vs %h", $time, a, b); end end
module idle_domain_config_bench;
   import idle_cfg_pkg::*;
   logic        core_clk_in = 1'h0, sys_rst_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0;
   logic        pwrite_in = 1'h0, idle_exec_in = 1'h0, pready_out, pslverr_out, bus_error_out;
   logic        irq_out, er, be;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
   domain_t     idle_out;
   int          miscompares = 0, check_count = 0;
   logic [31:0] wv [5] = '{32'hFFFFFFFF, 32'h1E0, 32'h10, 32'h3F0, 32'h120};
   logic [5:0]  ov [5] = '{6'h1F, 6'h0F, 6'h20, 6'h2F, 6'h09};
   idle_domain_config dut (.*);
   // core clock, 8 ns period
   initial forever #4 core_clk_in = ~core_clk_in;
   // request stands until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk_in);
      psel_in <= 1'h1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge core_clk_in);
      penable_in <= 1'h1;
      do @(posedge core_clk_in); while (pready_out !== 1'h1);
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 1'h0;
      penable_in <= 1'h0;
   endtask
   // one-cycle IDLE strobe, error pulse sampled once it has landed
   task automatic idle_pulse;
      @(posedge core_clk_in);
      idle_exec_in <= 1'h1;
      @(posedge core_clk_in);
      idle_exec_in <= 1'h0;
      @(negedge core_clk_in);
      be = bus_error_out;
   endtask
   task automatic test_done;
      $display("checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (12) @(posedge core_clk_in);
      sys_rst_in <= 1'h0;
      apb(1'h0, CFG_ADDR, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'h1, MASK_ADDR, 32'h1);
      for (int i = 0; i < 5; i++)
      begin
         apb(1'h1, CFG_ADDR, wv[i]);
         apb(1'h0, CFG_ADDR, 32'h0);
         `CHK(rd, wv[i] & 32'h3FF)
         `CHK(idle_out, i ? ov[i-1][4:0] : 5'h00)
         idle_pulse;
         `CHK({be, idle_out}, ov[i])
      end
      `CHK(irq_out, 1'h1)
      apb(1'h0, STATUS_ADDR, 32'h0);
      `CHK({er, rd}, 33'h3)
      apb(1'h0, ACTIVE_ADDR, 32'h0);
      `CHK(rd, 32'h9)
      apb(1'h1, MASK_ADDR, 32'h0);
      @(negedge core_clk_in);
      `CHK(irq_out, 1'h0)
      apb(1'h1, STATUS_ADDR, 32'h3);
      apb(1'h0, STATUS_ADDR, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'h1, MASK_ADDR, 32'h1);
      @(negedge core_clk_in);
      `CHK(irq_out, 1'h0)
      apb(1'h0, 12'h020, 32'h0);
      `CHK({er, rd}, 33'h100000000)
      // mid-run reset must clear the domains and the stored requests
      @(posedge core_clk_in);
      sys_rst_in <= 1'h1;
      repeat (2) @(posedge core_clk_in);
      sys_rst_in <= 1'h0;
      `CHK(idle_out, 5'h00)
      apb(1'h0, CFG_ADDR, 32'h0);
      `CHK(rd, 32'h0)
      test_done;
   end
   // hang guard
   initial
   begin
      repeat (2000) @(posedge core_clk_in);
      miscompares++;
      test_done;
   end
endmodule
`default_nettype wire
